// [rtl/ebs_pkg.sv]
// Purpose: Shared constants and types for the endpoint buffer status register bank
// Assumes: 16-bit register address, 8-bit data
// Notes:   Offsets are byte addresses in the controller's external data space
package ebs_pkg;
  localparam logic [15:0] OFS_EP2_CNT_HI   = 16'he690;
  localparam logic [15:0] OFS_EP2_CNT_LO   = 16'he691;
  localparam logic [15:0] OFS_EP4_CNT_HI   = 16'he694;
  localparam logic [15:0] OFS_EP4_CNT_LO   = 16'he695;
  localparam logic [15:0] OFS_EP6_CNT_HI   = 16'he698;
  localparam logic [15:0] OFS_EP6_CNT_LO   = 16'he699;
  localparam logic [15:0] OFS_EP8_CNT_HI   = 16'he69c;
  localparam logic [15:0] OFS_EP8_CNT_LO   = 16'he69d;
  localparam logic [15:0] OFS_EP0_STAT     = 16'he6a0;
  localparam logic [15:0] OFS_EP1OUT_STAT  = 16'he6a1;
  localparam logic [15:0] OFS_EP1IN_STAT   = 16'he6a2;
  localparam logic [15:0] OFS_EP2_STAT     = 16'he6a3;
  localparam logic [15:0] OFS_EP4_STAT     = 16'he6a4;
  localparam logic [15:0] OFS_EP6_STAT     = 16'he6a5;
  localparam logic [15:0] OFS_EP8_STAT     = 16'he6a6;
  localparam logic [15:0] OFS_EP2_QFLAGS   = 16'he6a7;
  localparam logic [15:0] OFS_EP4_QFLAGS   = 16'he6a8;
  localparam logic [15:0] OFS_EP6_QFLAGS   = 16'he6a9;
  localparam logic [15:0] OFS_EP8_QFLAGS   = 16'he6aa;
  localparam logic [15:0] OFS_EP2_QTOT_HI  = 16'he6ab;
  localparam logic [15:0] OFS_EP2_QTOT_LO  = 16'he6ac;
  localparam logic [15:0] OFS_EP4_QTOT_HI  = 16'he6ad;
  localparam logic [15:0] OFS_EP4_QTOT_LO  = 16'he6ae;
  // Own registers: interrupt status, mask, size select, combined mirror
  localparam logic [15:0] OFS_IRQ_STAT     = 16'he6f0;
  localparam logic [15:0] OFS_IRQ_MASK     = 16'he6f1;
  localparam logic [15:0] OFS_SIZE_SEL     = 16'he6f2;
  localparam logic [15:0] OFS_MIRROR       = 16'he6f3;
  // Field positions
  localparam int BIT_HANDSHAKE_NAK_BIT  = 7;
  localparam int BIT_FULL   = 3;
  localparam int BIT_EMPTY  = 2;
  localparam int BIT_BUSY   = 1;
  localparam int BIT_STALL  = 0;
  localparam int BIT_NPAK   = 4;
  localparam int BIT_PF     = 2;
  localparam int BIT_EF     = 1;
  localparam int BIT_FF     = 0;
  // Reset values
  localparam logic [7:0] RST_EP0_STAT   = 8'h80;
  localparam logic [7:0] RST_EP1_STAT   = 8'h00;
  localparam logic [7:0] RST_EP24_STAT  = 8'h28;
  localparam logic [7:0] RST_EP68_STAT  = 8'h04;
  localparam logic [7:0] RST_EP24_QFLG  = 8'h02;
  localparam logic [7:0] RST_EP68_QFLG  = 8'h06;
  localparam logic [7:0] RST_ZERO       = 8'h00;
  // Per-endpoint state reported by the buffer engine
  typedef struct packed {
    logic [2:0] packetCount;
    logic       full;
    logic       empty;
    logic       progLevel;
    logic       queueFull;
    logic       queueEmpty;
  } ebs_ep_state_t;
  // Register bus request
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } ebs_bus_req_t;
endpackage

// [rtl/ebs_regs.sv]
// Purpose: Endpoint buffer status and control register bank
// Assumes: Buffer engine inputs are synchronous to clock; plain strobe register port
// Notes:   Read data valid one cycle after the read strobe
// Behaviour
// - Endpoints 2 and 6 select small or large buffers; 4 and 8 small only
// - Endpoint 2 and 6 byte count is 11 bits, 3 high plus 8 low
// - Endpoint 4 and 8 byte count is 10 bits, upper high bits read zero
// - Low count bit 7 doubles as skip control; reset value undefined
// - Control status: handshake-NAK bit 7, busy bit 1 ro, stall bit 0; resets 0x80
// - Endpoint 1 IN/OUT status: busy ro, stall writable, reset zero
// - Packet count 0-4 on endpoints 2,6; 0-2 on endpoints 4,8
// - OUT counts received packets; IN counts armed packets
// - Bulk status: full bit 3, empty bit 2, stall bit 0 writable only
// - Endpoints 2,4 reset two-packet full; 6,8 reset empty only
// - Full and empty bits mirrored into a combined register
// - Queue flag registers read-only: level bit 2, empty 1, full 0
// - Endpoint 2 total is 13 bits, endpoint 4 total 11 bits, read-only
// - OUT total is bytes held; IN total is bytes in current packet
`timescale 1ns/100ps
`default_nettype none
module ebs_regs
  import ebs_pkg::*;
(
  input  wire logic          clock,        // 50 MHz system clock
  input  wire logic          rst_b,        // Asynchronous reset, active low
  input  wire ebs_bus_req_t  busReq,       // Register address, data and strobes
  output logic        [7:0]  rdData,       // Read data, one cycle after strobe
  input  wire ebs_ep_state_t epState [4],  // Engine state for endpoints 2,4,6,8
  input  wire logic   [3:0]  epIsIn,       // Direction per endpoint, 1 = IN
  input  wire logic   [2:0]  ctrlBusy,     // Busy for control, ep1 out, ep1 in
  input  wire logic          hsNakSet,     // Setup arrived, handshake-NAK rises
  input  wire logic   [12:0] ep2TotalOut,  // Bytes held in ep2 queue
  input  wire logic   [12:0] ep2TotalIn,   // Bytes in ep2 packet being filled
  input  wire logic   [10:0] ep4TotalOut,  // Bytes held in ep4 queue
  input  wire logic   [10:0] ep4TotalIn,   // Bytes in ep4 packet being filled
  output logic        [3:0]  countLoad,    // Pulse: low count written per endpoint
  output logic        [10:0] countValue [4], // Byte count per endpoint
  output logic        [3:0]  skipCtl,      // Skip control bit per endpoint
  output logic        [4:0]  stallOut,     // Stall: bit 0 zero, then ep0,ep1out,ep1in; bit 4 is any of ep2..8
  output logic        [3:0]  stallBulk,    // Stall for endpoints 2,4,6,8
  output logic               handshake_nak_bit,        // Handshake-NAK level
  output logic        [1:0]  largeBuf,     // Large buffer select for ep2, ep6
  output logic               irq           // Interrupt, high while unmasked event set
);

  // Byte-count field width per endpoint slot
  function automatic logic [7:0] hiByte(input logic [10:0] c, input int s);
    hiByte = (s == 0 || s == 2) ? {5'h00, c[10:8]} : {6'h00, c[9:8]};
  endfunction

  localparam logic [15:0] CNT_HI [4] = '{OFS_EP2_CNT_HI, OFS_EP4_CNT_HI,
                                         OFS_EP6_CNT_HI, OFS_EP8_CNT_HI};
  localparam logic [15:0] CNT_LO [4] = '{OFS_EP2_CNT_LO, OFS_EP4_CNT_LO,
                                         OFS_EP6_CNT_LO, OFS_EP8_CNT_LO};
  localparam logic [15:0] ST_OFS [4] = '{OFS_EP2_STAT, OFS_EP4_STAT,
                                         OFS_EP6_STAT, OFS_EP8_STAT};
  localparam logic [15:0] QF_OFS [4] = '{OFS_EP2_QFLAGS, OFS_EP4_QFLAGS,
                                         OFS_EP6_QFLAGS, OFS_EP8_QFLAGS};

  // Mirror level of an engine at its reset state, so no false event follows reset
  localparam logic [7:0] MIRROR_RST = {RST_EP68_STAT[BIT_FULL], RST_EP68_STAT[BIT_EMPTY],
                                       RST_EP68_STAT[BIT_FULL], RST_EP68_STAT[BIT_EMPTY],
                                       RST_EP24_STAT[BIT_FULL], RST_EP24_STAT[BIT_EMPTY],
                                       RST_EP24_STAT[BIT_FULL], RST_EP24_STAT[BIT_EMPTY]};

  logic [10:0] cntReg [4];
  logic [3:0]  stallReg;
  logic [2:0]  ctlStall;
  logic        hsNakReg;
  logic [1:0]  sizeSel;
  logic [7:0]  irqStat;
  logic [7:0]  irqMask;
  logic [7:0]  prevFlags;
  logic [7:0]  statView [4];
  logic [7:0]  qflView  [4];
  logic [7:0]  mirror;
  logic [12:0] ep2Total;
  logic [10:0] ep4Total;
  logic [7:0]  next_rdData;
  logic [7:0]  curFlags;
  logic [7:0]  next_irqStat;
  logic [7:0]  next_irqMask;
  logic [3:0]  hiWr;
  logic [3:0]  loWr;
  logic [3:0]  stWr;
  logic        wr;

  assign wr = busReq.wr;

  // Per-endpoint decode and status views
  for (genvar i = 0; i < 4; i++) begin : g_ep
    logic [2:0] npak;
    assign hiWr[i] = wr && (busReq.addr == CNT_HI[i]);
    assign loWr[i] = wr && (busReq.addr == CNT_LO[i]);
    assign stWr[i] = wr && (busReq.addr == ST_OFS[i]);
    // Engine counts received packets for OUT and armed packets for IN
    assign npak = (i == 0 || i == 2) ? epState[i].packetCount
                                     : {1'b0, epState[i].packetCount[1:0]};
    assign statView[i] = {1'b0, npak, epState[i].full, epState[i].empty,
                          1'b0, stallReg[i]};
    assign qflView[i] = {5'h00, epState[i].progLevel, epState[i].queueEmpty,
                         epState[i].queueFull};
  end

  // Combined full/empty mirror, empty in even bits, full in odd
  assign mirror = {statView[3][BIT_FULL], statView[3][BIT_EMPTY],
                   statView[2][BIT_FULL], statView[2][BIT_EMPTY],
                   statView[1][BIT_FULL], statView[1][BIT_EMPTY],
                   statView[0][BIT_FULL], statView[0][BIT_EMPTY]};

  // Totals follow direction
  assign ep2Total = epIsIn[0] ? ep2TotalIn : ep2TotalOut;
  assign ep4Total = epIsIn[1] ? ep4TotalIn : ep4TotalOut;

  // Read mux; unmapped addresses and unused bits return zero
  always_comb begin
    next_rdData = RST_ZERO;
    if (busReq.addr == OFS_EP0_STAT)
      next_rdData = {hsNakReg, 5'h00, ctrlBusy[0], ctlStall[0]};
    else if (busReq.addr == OFS_EP1OUT_STAT)
      next_rdData = {6'h00, ctrlBusy[1], ctlStall[1]};
    else if (busReq.addr == OFS_EP1IN_STAT)
      next_rdData = {6'h00, ctrlBusy[2], ctlStall[2]};
    else if (busReq.addr == OFS_EP2_QTOT_HI)
      next_rdData = {3'h0, ep2Total[12:8]};
    else if (busReq.addr == OFS_EP2_QTOT_LO)
      next_rdData = ep2Total[7:0];
    else if (busReq.addr == OFS_EP4_QTOT_HI)
      next_rdData = {5'h00, ep4Total[10:8]};
    else if (busReq.addr == OFS_EP4_QTOT_LO)
      next_rdData = ep4Total[7:0];
    else if (busReq.addr == OFS_IRQ_STAT)
      next_rdData = irqStat;
    else if (busReq.addr == OFS_IRQ_MASK)
      next_rdData = irqMask;
    else if (busReq.addr == OFS_SIZE_SEL)
      next_rdData = {6'h00, sizeSel};
    else if (busReq.addr == OFS_MIRROR)
      next_rdData = mirror;
    else begin
      for (int i = 0; i < 4; i++) begin
        if (busReq.addr == CNT_HI[i])
          next_rdData = hiByte(cntReg[i], i);
        if (busReq.addr == CNT_LO[i])
          next_rdData = cntReg[i][7:0];
        if (busReq.addr == ST_OFS[i])
          next_rdData = statView[i];
        if (busReq.addr == QF_OFS[i])
          next_rdData = qflView[i];
      end
    end
  end

  // Interrupt events: full rise and empty rise on each bulk endpoint
  assign curFlags = mirror;
  always_comb begin
    next_irqStat = irqStat;
    if (wr && busReq.addr == OFS_IRQ_STAT)
      next_irqStat = irqStat & ~busReq.wdata;
    // Set wins over a same-cycle clear so no event is lost
    next_irqStat = next_irqStat | (curFlags & ~prevFlags);
  end

  // Mask follows its write at once, so irq tracks status and mask together
  assign next_irqMask = (wr && busReq.addr == OFS_IRQ_MASK) ? busReq.wdata : irqMask;

  // Read data and interrupt registers
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rdData    <= RST_ZERO;
      irqStat   <= RST_ZERO;
      irqMask   <= RST_ZERO;
      prevFlags <= MIRROR_RST;
      irq       <= 1'b0;
    end else begin
      rdData    <= busReq.rd ? next_rdData : RST_ZERO;
      irqStat   <= next_irqStat;
      prevFlags <= curFlags;
      irq       <= |(next_irqStat & next_irqMask);
      irqMask   <= next_irqMask;
    end
  end

  // Byte counts; bit 7 of low byte doubles as skip control and has no reset
  always_ff @(posedge clock) begin
    for (int i = 0; i < 4; i++) begin
      if (hiWr[i])
        cntReg[i][10:8] <= (i == 0 || i == 2) ? busReq.wdata[2:0]
                                              : {1'b0, busReq.wdata[1:0]};
      if (loWr[i])
        cntReg[i][7:0] <= busReq.wdata;
    end
  end

  // Count outputs and load pulses
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      countLoad <= 4'h0;
      skipCtl   <= 4'h0;
      for (int i = 0; i < 4; i++)
        countValue[i] <= 11'h000;
    end else begin
      countLoad <= loWr;
      for (int i = 0; i < 4; i++) begin
        countValue[i] <= cntReg[i];
        skipCtl[i]    <= cntReg[i][7];
      end
    end
  end

  // Control bits; busy, full, empty and counts come from the engine, writes ignored
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      hsNakReg <= RST_EP0_STAT[BIT_HANDSHAKE_NAK_BIT];
      ctlStall <= {RST_EP1_STAT[BIT_STALL], RST_EP1_STAT[BIT_STALL],
                   RST_EP0_STAT[BIT_STALL]};
      stallReg <= {RST_EP68_STAT[BIT_STALL], RST_EP68_STAT[BIT_STALL],
                   RST_EP24_STAT[BIT_STALL], RST_EP24_STAT[BIT_STALL]};
      sizeSel  <= 2'h0;
    end else begin
      // Firmware clears handshake-NAK by writing one; a new setup wins
      if (hsNakSet)
        hsNakReg <= 1'b1;
      else if (wr && busReq.addr == OFS_EP0_STAT && busReq.wdata[BIT_HANDSHAKE_NAK_BIT])
        hsNakReg <= 1'b0;
      if (wr && busReq.addr == OFS_EP0_STAT)
        ctlStall[0] <= busReq.wdata[BIT_STALL];
      if (wr && busReq.addr == OFS_EP1OUT_STAT)
        ctlStall[1] <= busReq.wdata[BIT_STALL];
      if (wr && busReq.addr == OFS_EP1IN_STAT)
        ctlStall[2] <= busReq.wdata[BIT_STALL];
      for (int i = 0; i < 4; i++)
        if (stWr[i])
          stallReg[i] <= busReq.wdata[BIT_STALL];
      // Only endpoints 2 and 6 may take the large buffer
      if (wr && busReq.addr == OFS_SIZE_SEL)
        sizeSel <= busReq.wdata[1:0];
    end
  end

  // Registered control outputs
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      stallOut  <= 5'h00;
      stallBulk <= 4'h0;
      handshake_nak_bit     <= RST_EP0_STAT[BIT_HANDSHAKE_NAK_BIT];
      largeBuf  <= 2'h0;
    end else begin
      stallOut  <= {|stallReg, ctlStall[2], ctlStall[1], ctlStall[0], 1'b0};
      stallBulk <= stallReg;
      handshake_nak_bit     <= hsNakReg;
      largeBuf  <= sizeSel;
    end
  end

  // Read data appears only in the cycle after the strobe
  property p_rd_zero;
    @(posedge clock) disable iff (!rst_b) !busReq.rd |=> rdData == 8'h00;
  endproperty
  a_rd_zero: assert property (p_rd_zero) else $error("read data not zero when idle");

  property p_ep0_read;
    @(posedge clock) disable iff (!rst_b)
      busReq.rd && busReq.addr == OFS_EP0_STAT |=> rdData[6:2] == 5'h00;
  endproperty
  a_ep0_read: assert property (p_ep0_read) else $error("ep0 unused bits set");

  property p_handshake_nak_bit_set;
    @(posedge clock) disable iff (!rst_b) hsNakSet |=> ##1 handshake_nak_bit;
  endproperty
  a_handshake_nak_bit_set: assert property (p_handshake_nak_bit_set) else $error("handshake-nak not set");

  property p_ep4_hi;
    @(posedge clock) disable iff (!rst_b)
      busReq.rd && busReq.addr == OFS_EP4_CNT_HI |=> rdData[7:2] == 6'h00;
  endproperty
  a_ep4_hi: assert property (p_ep4_hi) else $error("ep4 count high too wide");

  property p_ep2_hi;
    @(posedge clock) disable iff (!rst_b)
      busReq.rd && busReq.addr == OFS_EP2_CNT_HI |=> rdData[7:3] == 5'h00;
  endproperty
  a_ep2_hi: assert property (p_ep2_hi) else $error("ep2 count high too wide");

  property p_stall_wr;
    @(posedge clock) disable iff (!rst_b)
      busReq.wr && busReq.addr == OFS_EP2_STAT |=> ##1 stallBulk[0] == $past(busReq.wdata[0], 2);
  endproperty
  a_stall_wr: assert property (p_stall_wr) else $error("ep2 stall not written");

  property p_qflags;
    @(posedge clock) disable iff (!rst_b)
      busReq.rd && busReq.addr == OFS_EP6_QFLAGS
      |=> rdData == {5'h00, $past(epState[2].progLevel), $past(epState[2].queueEmpty),
                     $past(epState[2].queueFull)};
  endproperty
  a_qflags: assert property (p_qflags) else $error("queue flags mismatch");

  property p_ep4_npak;
    @(posedge clock) disable iff (!rst_b)
      busReq.rd && busReq.addr == OFS_EP4_STAT |=> !rdData[6];
  endproperty
  a_ep4_npak: assert property (p_ep4_npak) else $error("ep4 packet count too wide");

  property p_tot2;
    @(posedge clock) disable iff (!rst_b)
      busReq.rd && busReq.addr == OFS_EP2_QTOT_HI
      |=> rdData == {3'h0, $past(epIsIn[0] ? ep2TotalIn[12:8] : ep2TotalOut[12:8])};
  endproperty
  a_tot2: assert property (p_tot2) else $error("ep2 total mismatch");

  // Interrupt level always equals any unmasked status bit being set
  property p_irq;
    @(posedge clock) disable iff (!rst_b) irq == ((irqStat & irqMask) != 8'h00);
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt level wrong");

  // A rising mirror bit lands in status even beside a clear
  property p_irq_set;
    @(posedge clock) disable iff (!rst_b) (curFlags & ~prevFlags) != 8'h00
      |=> (irqStat & $past(curFlags & ~prevFlags)) == $past(curFlags & ~prevFlags);
  endproperty
  a_irq_set: assert property (p_irq_set) else $error("interrupt event lost");

  // Handshake-NAK clear: a one written at bit 7 with no setup beside it
  sequence s_handshake_nak_bit_clr;
    busReq.wr && busReq.addr == OFS_EP0_STAT && busReq.wdata[BIT_HANDSHAKE_NAK_BIT] && !hsNakSet;
  endsequence

  property p_handshake_nak_bit_clr;
    @(posedge clock) disable iff (!rst_b) s_handshake_nak_bit_clr |=> ##1 !handshake_nak_bit;
  endproperty
  a_handshake_nak_bit_clr: assert property (p_handshake_nak_bit_clr) else $error("handshake-nak not cleared");

  property p_ep1in_read;
    @(posedge clock) disable iff (!rst_b)
      busReq.rd && busReq.addr == OFS_EP1IN_STAT |=> rdData[7:2] == 6'h00;
  endproperty
  a_ep1in_read: assert property (p_ep1in_read) else $error("ep1 in unused bits set");

  property p_ep1out_stall;
    @(posedge clock) disable iff (!rst_b) busReq.wr && busReq.addr == OFS_EP1OUT_STAT
      |=> ##1 stallOut[2] == $past(busReq.wdata[BIT_STALL], 2);
  endproperty
  a_ep1out_stall: assert property (p_ep1out_stall) else $error("ep1 out stall lost");

  property p_ep8_npak;
    @(posedge clock) disable iff (!rst_b)
      busReq.rd && busReq.addr == OFS_EP8_STAT |=> rdData[7:6] == 2'h0;
  endproperty
  a_ep8_npak: assert property (p_ep8_npak) else $error("ep8 packet count too wide");

  property p_ep4_hi_wr;
    @(posedge clock) disable iff (!rst_b)
      busReq.wr && busReq.addr == OFS_EP4_CNT_HI |=> cntReg[1][10] == 1'b0;
  endproperty
  a_ep4_hi_wr: assert property (p_ep4_hi_wr) else $error("ep4 count bit 10 stored");

  property p_skip;
    @(posedge clock) disable iff (!rst_b) busReq.wr && busReq.addr == OFS_EP6_CNT_LO
      |=> ##1 skipCtl[2] == $past(busReq.wdata[7], 2);
  endproperty
  a_skip: assert property (p_skip) else $error("ep6 skip control lost");

  property p_size;
    @(posedge clock) disable iff (!rst_b) busReq.wr && busReq.addr == OFS_SIZE_SEL
      |=> ##1 largeBuf == $past(busReq.wdata[1:0], 2);
  endproperty
  a_size: assert property (p_size) else $error("buffer size select lost");

  property p_tot4;
    @(posedge clock) disable iff (!rst_b)
      busReq.rd && busReq.addr == OFS_EP4_QTOT_HI |=> rdData[7:3] == 5'h00;
  endproperty
  a_tot4: assert property (p_tot4) else $error("ep4 total too wide");

  property p_mirror;
    @(posedge clock) disable iff (!rst_b) busReq.rd && busReq.addr == OFS_MIRROR
      |=> rdData[1:0] == {$past(epState[0].full), $past(epState[0].empty)};
  endproperty
  a_mirror: assert property (p_mirror) else $error("ep2 mirror bits wrong");

  property p_unmapped;
    @(posedge clock) disable iff (!rst_b)
      busReq.rd && busReq.addr == OFS_EP2_CNT_LO + 16'h0001 |=> rdData == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

endmodule
`default_nettype wire

// [test/test_endpoint_buffer_status_regs.sv]
// Purpose: Self-checking bench for the endpoint buffer status register bank
// Assumes: Read data is taken in the cycle after the read strobe
// Notes:   Engine inputs are random levels; stall and handshake state are modelled here
`timescale 1ns/100ps
`default_nettype none
module test_endpoint_buffer_status_regs
  import ebs_pkg::*;
;
  logic          clock;
  logic          rst_b;
  ebs_bus_req_t  busReq;
  logic [7:0]    rdData;
  ebs_ep_state_t epState [4];
  logic [3:0]    epIsIn;
  logic [2:0]    ctrlBusy;
  logic          hsNakSet;
  logic [12:0]   ep2TotalOut;
  logic [12:0]   ep2TotalIn;
  logic [10:0]   ep4TotalOut;
  logic [10:0]   ep4TotalIn;
  logic [3:0]    countLoad;
  logic [10:0]   countValue [4];
  logic [3:0]    skipCtl;
  logic [4:0]    stallOut;
  logic [3:0]    stallBulk;
  logic          handshake_nak_bit;
  logic [1:0]    largeBuf;
  logic          irq;
  logic [6:0]    stallM;
  logic          hsNakM;
  int            failCount;
  int            testsRun;

  ebs_regs ebs_regs_inst (
    .clock(clock), .rst_b(rst_b), .busReq(busReq), .rdData(rdData), .epState(epState),
    .epIsIn(epIsIn), .ctrlBusy(ctrlBusy), .hsNakSet(hsNakSet), .ep2TotalOut(ep2TotalOut),
    .ep2TotalIn(ep2TotalIn), .ep4TotalOut(ep4TotalOut), .ep4TotalIn(ep4TotalIn),
    .countLoad(countLoad), .countValue(countValue), .skipCtl(skipCtl), .stallOut(stallOut),
    .stallBulk(stallBulk), .handshake_nak_bit(handshake_nak_bit), .largeBuf(largeBuf), .irq(irq)
  );

  // 50 MHz clock
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  task automatic check(input string what, input logic [12:0] seen, input logic [12:0] exp);
    testsRun++;
    if (seen !== exp) begin
      failCount++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic results();
    $display("Checks made %0d, mismatches %0d", testsRun, failCount);
    if (failCount == 0 && testsRun > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Strobes rise after one edge and drop after the edge that takes them
  task automatic busWrite(input logic [15:0] a, input logic [7:0] d);
    @(posedge clock);
    busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    busReq.wr <= 1'b0;
    #1;
  endtask

  task automatic rdChk(input string what, input logic [15:0] a, input logic [7:0] e);
    @(posedge clock);
    busReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    busReq.rd <= 1'b0;
    #1;
    check(what, rdData, e);
  endtask

  // Bounded wait: a level that never comes shows up as a mismatch
  task automatic waitIrq(input logic e);
    for (int n = 0; n < 8 && irq !== e; n++) begin
      @(posedge clock);
      #1;
    end
    check("irq", irq, e);
  endtask

  // Packet count of the small endpoints has only two bits
  function automatic logic [7:0] expStat(input int i);
    logic [2:0] pc;
    pc = epState[i].packetCount;
    if (i % 2 == 1) begin
      pc[2] = 1'b0;
    end
    return {1'b0, pc, epState[i].full, epState[i].empty, 1'b0, stallM[3+i]};
  endfunction

  function automatic logic [7:0] expMirror();
    logic [7:0] m;
    for (int i = 0; i < 4; i++) begin
      m[2*i +: 2] = {epState[i].full, epState[i].empty};
    end
    return m;
  endfunction

  task automatic checkAll();
    logic [12:0] t2;
    logic [12:0] t4;
    t2 = epIsIn[0] ? ep2TotalIn : ep2TotalOut;
    t4 = {2'h0, epIsIn[1] ? ep4TotalIn : ep4TotalOut};
    for (int i = 0; i < 4; i++) begin
      rdChk("bulk status", OFS_EP2_STAT + 16'(i), expStat(i));
      rdChk("queue flags", OFS_EP2_QFLAGS + 16'(i), {5'h00, epState[i].progLevel,
            epState[i].queueEmpty, epState[i].queueFull});
    end
    rdChk("ep2 total hi", OFS_EP2_QTOT_HI, {3'h0, t2[12:8]});
    rdChk("ep2 total lo", OFS_EP2_QTOT_LO, t2[7:0]);
    rdChk("ep4 total hi", OFS_EP4_QTOT_HI, {5'h00, t4[10:8]});
    rdChk("ep4 total lo", OFS_EP4_QTOT_LO, t4[7:0]);
    rdChk("ctrl status", OFS_EP0_STAT, {hsNakM, 5'h00, ctrlBusy[0], stallM[0]});
    rdChk("ep1 out status", OFS_EP1OUT_STAT, {6'h00, ctrlBusy[1], stallM[1]});
    rdChk("ep1 in status", OFS_EP1IN_STAT, {6'h00, ctrlBusy[2], stallM[2]});
    rdChk("mirror", OFS_MIRROR, expMirror());
    check("stallBulk", stallBulk, stallM[6:3]);
    check("stallOut", stallOut, {|stallM[6:3], stallM[2:0], 1'b0});
    check("handshake_nak_bit", handshake_nak_bit, hsNakM);
  endtask

  // Engine levels as they stand after a device reset
  task automatic engineReset();
    for (int i = 0; i < 4; i++) begin
      epState[i] = '{packetCount: (i < 2) ? 3'h2 : 3'h0, full: i < 2, empty: i >= 2,
                     progLevel: i >= 2, queueFull: 1'b0, queueEmpty: 1'b1};
    end
    stallM = 7'h00;
    hsNakM = 1'b1;
  endtask

  // Main sequence
  initial begin
    logic [7:0]  hi;
    logic [7:0]  lo;
    logic [10:0] cv;
    int          k;
    busReq = '0;
    rst_b = 1'b0;
    epIsIn = 4'h0;
    ctrlBusy = 3'h0;
    hsNakSet = 1'b0;
    {ep2TotalOut, ep2TotalIn, ep4TotalOut, ep4TotalIn} = '0;
    failCount = 0;
    testsRun = 0;
    engineReset();
    void'($urandom(67447));
    repeat (12) @(posedge clock);
    rst_b <= 1'b1;
    rdChk("ep2 status reset", OFS_EP2_STAT, RST_EP24_STAT);
    rdChk("ep8 status reset", OFS_EP8_STAT, RST_EP68_STAT);
    rdChk("ep6 flags reset", OFS_EP6_QFLAGS, RST_EP68_QFLG);
    checkAll();
    $display("Test reset values done");
    // Random engine levels, stall writes and handshake pulses
    for (int n = 0; n < 24; n++) begin
      @(posedge clock);
      for (int i = 0; i < 4; i++) begin
        epState[i] <= '{packetCount: 3'($urandom_range(0, (i % 2) ? 2 : 4)),
                        full: 1'($urandom), empty: 1'($urandom), progLevel: 1'($urandom),
                        queueFull: 1'($urandom), queueEmpty: 1'($urandom)};
      end
      epIsIn <= 4'($urandom);
      ctrlBusy <= 3'($urandom);
      {ep2TotalOut, ep2TotalIn, ep4TotalOut, ep4TotalIn} <= 48'({$urandom, $urandom});
      k = $urandom_range(0, 6);
      lo = (n < 7) ? 8'hff : 8'($urandom);
      busWrite(OFS_EP0_STAT + 16'(k), lo);
      stallM[k] = lo[0];
      hsNakM = (k == 0 && lo[7]) ? 1'b0 : hsNakM;
      if (n % 5 == 4) begin
        @(posedge clock);
        hsNakSet <= 1'b1;
        @(posedge clock);
        hsNakSet <= 1'b0;
        hsNakM = 1'b1;
      end
      checkAll();
    end
    $display("Test random status done");
    // Byte counts, all ones first
    for (int i = 0; i < 4; i++) begin
      hi = (i == 0) ? 8'hff : 8'($urandom);
      lo = (i == 0) ? 8'hff : 8'($urandom);
      cv = (i % 2) ? {1'b0, hi[1:0], lo} : {hi[2:0], lo};
      busWrite(OFS_EP2_CNT_HI + 16'(4 * i), hi);
      busWrite(OFS_EP2_CNT_HI + 16'(4 * i + 1), lo);
      for (int n = 0; n < 4 && countLoad !== (4'h1 << i); n++) begin
        @(posedge clock);
        #1;
      end
      check("countLoad", countLoad, 4'h1 << i);
      // Value and skip bit follow the load pulse by one cycle
      @(posedge clock);
      #1;
      check("countValue", countValue[i], cv);
      check("skipCtl", skipCtl[i], lo[7]);
      rdChk("count hi", OFS_EP2_CNT_HI + 16'(4 * i), {5'h00, cv[10:8]});
      rdChk("count lo", OFS_EP2_CNT_HI + 16'(4 * i + 1), lo);
    end
    $display("Test byte counts done");
    busWrite(OFS_SIZE_SEL, 8'hff);
    rdChk("size select", OFS_SIZE_SEL, 8'h03);
    check("largeBuf", largeBuf, 2'h3);
    busWrite(OFS_SIZE_SEL, 8'h02);
    @(posedge clock);
    #1;
    check("largeBuf", largeBuf, 2'h2);
    busWrite(OFS_EP2_QFLAGS, 8'hff);
    busWrite(OFS_EP4_QTOT_LO, 8'hff);
    rdChk("unmapped", 16'he692, 8'h00);
    checkAll();
    $display("Test size and read-only done");
    // Interrupt from a rising empty bit: masked, unmasked, cleared
    busWrite(OFS_IRQ_MASK, 8'h00);
    for (int i = 0; i < 4; i++) begin
      epState[i] <= '0;
    end
    busWrite(OFS_IRQ_STAT, 8'hff);
    epState[0].empty <= 1'b1;
    busWrite(OFS_IRQ_STAT, 8'h00);
    rdChk("irq status", OFS_IRQ_STAT, 8'h01);
    waitIrq(1'b0);
    busWrite(OFS_IRQ_MASK, 8'h01);
    waitIrq(1'b1);
    busWrite(OFS_IRQ_STAT, 8'h01);
    waitIrq(1'b0);
    rdChk("irq status", OFS_IRQ_STAT, 8'h00);
    $display("Test interrupt done");
    // Second reset in mid-run
    @(posedge clock);
    rst_b <= 1'b0;
    #1;
    engineReset();
    repeat (3) @(posedge clock);
    rst_b <= 1'b1;
    checkAll();
    $display("Test second reset done");
    results();
  end
endmodule
`default_nettype wire
